// *** rtl/rmb_backoff_core.sv ***
// Purpose: retransmission timeout and channel access delay timing core
// Assumes: one clock, frame logic and busy detector on the same clock
// Notes:
// Notes on behaviour
// - retransmission timeouts are computed only with ack on and retries above zero
// - timeout is fixed part plus random 0..max times variable part plus progressive
// - progressive term is fixed times (sequence minus one), zero when off
// - fixed part clamped 10..10000 bytes, always included, as airtime
// - variable part clamped 10..10000 bytes, airtime times random multiplier
// - maximum random multiplier clamped to 0..15
// - busy extra delay up to 16000 bytes added only on a busy channel
// - slot length up to 250 bytes, zero means shortest frame
// - after data reception draw slot count from 0..slots_after_rx
// - after own data transmission draw slot count from 0..slots_after_tx
// - acknowledgement frames never change the remembered previous event
// - slot handicap 0..7 is always added to the random slot count
// - handicap plus random slot count saturates at 14
// - on a free channel apply collision delay with given percent probability
// - collision delay 1..16000 bytes replaces the zero free-channel period
// - on a busy channel the collision delay is ignored
`timescale 1ns/1ps

module rmb_backoff_core
    import rmb_pkg::*;
#(
    parameter int MIN_FRAME_BYTES = 16    // bytes of the shortest frame
)
(
    input  wire logic                 clk,               // 25 MHz clock
    input  wire logic                 rst,               // async reset, high
    input  wire logic [PER_W-1:0]     byte_period,       // cycles per byte
    input  wire logic                 ack_enable,        // ack on
    input  wire logic [3:0]           retry_count,       // configured retries
    input  wire logic                 progressive_en,    // progressivity on
    input  wire logic [BYTE_W-1:0]    fixed_wait_part,   // fixed part, bytes
    input  wire logic [BYTE_W-1:0]    random_wait_unit,  // variable part, bytes
    input  wire logic [MULT_W-1:0]    max_random_multiplier, // multiplier max
    input  wire logic [BYTE_W-1:0]    busy_extra_bytes,  // busy extra delay
    input  wire logic [7:0]           slot_bytes,        // slot length
    input  wire logic [SLOTN_W-1:0]   slots_after_rx,    // range after rx
    input  wire logic [SLOTN_W-1:0]   slots_after_tx,    // range after tx
    input  wire logic [SLOTN_W-1:0]   slot_handicap,     // fixed handicap
    input  wire logic [PCT_W-1:0]     prevent_percent,   // probability
    input  wire logic [BYTE_W-1:0]    prevent_bytes,     // collision delay
    input  wire logic                 rx_frame_done,     // frame received
    input  wire logic                 tx_frame_done,     // frame sent
    input  wire logic                 frame_is_ack,      // done frame is ack
    input  wire logic                 timeout_req,       // start timeout
    input  wire logic [SEQ_W-1:0]     retry_sequence_number, // 0 = first
    input  wire logic                 timeout_cancel,    // ack arrived
    input  wire logic                 access_req,        // start access wait
    input  wire logic                 channel_busy,      // channel busy now
    output logic [TIME_W-1:0]         retry_timeout,     // computed cycles
    output logic                      timeout_valid,     // value pulse
    output logic                      timeout_running,   // counting
    output logic                      timeout_expired,   // expiry pulse
    output logic [TIME_W-1:0]         access_delay,      // computed cycles
    output logic                      access_valid,      // value pulse
    output logic                      access_running,    // counting
    output logic                      access_grant,      // may transmit
    output logic                      last_event_tx      // previous event tx
);

    // the slot length for zero must fit the slot field
    if (MIN_FRAME_BYTES < 1 || MIN_FRAME_BYTES > 255)
    begin : g_chk
        $error("MIN_FRAME_BYTES must lie in 1..255");
    end

    // byte count times period times multiplier must fit the delay width
    if (TIME_W < BYTE_W + PER_W + 5)
    begin : g_wchk
        $error("TIME_W too narrow for the delay products");
    end

    localparam logic [7:0] MIN_FRAME = 8'(MIN_FRAME_BYTES);

    // uniform draw over 0..max from 16 random bits, by multiply-high
    function automatic logic [4:0] draw(input logic [15:0] r,
                                        input logic [4:0]  max);
        logic [20:0] p;
        p = 21'(r) * 21'({1'b0, max} + 6'h01);
        return p[20:16];
    endfunction

    // uniform draw over 0..99 for the percentage test
    function automatic logic [6:0] draw7(input logic [15:0] r);
        logic [22:0] p;
        p = 23'(r) * 23'(PCT_MAX);
        return p[22:16];
    endfunction

    // saturate a small count field at its upper limit
    function automatic logic [3:0] sat4(input logic [3:0] v, input logic [3:0] hi);
        return (v > hi) ? hi : v;
    endfunction

    // clamp helper for byte counts
    function automatic logic [BYTE_W-1:0] clamp(input logic [BYTE_W-1:0] v,
                                                input logic [BYTE_W-1:0] lo,
                                                input logic [BYTE_W-1:0] hi);
        logic [BYTE_W-1:0] r;
        r = v;
        if (v < lo)
            r = lo;
        else if (v > hi)
            r = hi;
        return r;
    endfunction

    // generator and previous event
    logic [31:0]       lfsr_q;
    logic [31:0]       lfsr_d;
    rmb_event_t        last_ev_q;
    rmb_event_t        last_ev_d;

    // timeout countdown state
    logic [TIME_W-1:0] rto_q;
    logic [TIME_W-1:0] rto_d;
    logic              rto_v_q;
    logic [TIME_W-1:0] rto_cnt_q;
    logic [TIME_W-1:0] rto_cnt_d;
    logic              rto_run_q;
    logic              rto_run_d;
    logic              rto_exp_q;
    logic              rto_exp_d;

    // access countdown state
    logic [TIME_W-1:0] acc_q;
    logic [TIME_W-1:0] acc_d;
    logic              acc_v_q;
    logic [TIME_W-1:0] acc_cnt_q;
    logic [TIME_W-1:0] acc_cnt_d;
    logic              acc_run_q;
    logic              acc_run_d;
    logic              acc_gnt_q;
    logic              acc_gnt_d;

    // free running generator, steps every cycle so draws decorrelate
    assign lfsr_d = lfsr_q[0] ? ((lfsr_q >> 1) ^ LFSR_TAPS)
                              : (lfsr_q >> 1);

    // random fields for the draws; rnd_mult and rnd_slot are disjoint, rnd_pct reuses bits of both
    wire [15:0] rnd_mult = lfsr_q[15:0];
    wire [15:0] rnd_slot = lfsr_q[31:16];
    wire [15:0] rnd_pct  = {lfsr_q[7:0], lfsr_q[31:24]};

    // clamped configuration
    // clamping rather than refusing keeps a bad setting from stalling the mac
    wire [BYTE_W-1:0] fix_b  =
        clamp(fixed_wait_part, FIX_MIN, FIX_MAX);
    wire [BYTE_W-1:0] var_b  =
        clamp(random_wait_unit, VAR_MIN, VAR_MAX);
    wire [BYTE_W-1:0] txd_b  =
        clamp(busy_extra_bytes, TXD_DEF, TXD_MAX);
    wire [BYTE_W-1:0] cpd_b  =
        clamp(prevent_bytes, CPD_MIN, CPD_MAX);
    wire [MULT_W-1:0] mult_m = sat4(max_random_multiplier, MULT_MAX);
    wire [SLOTN_W-1:0] srx_m = sat4(slots_after_rx, SLOTS_MAX);
    wire [SLOTN_W-1:0] stx_m = sat4(slots_after_tx, SLOTS_MAX);
    wire [SLOTN_W-1:0] hc_m  = sat4(slot_handicap, HCAP_MAX);
    wire [PCT_W-1:0]   pct_m = (prevent_percent > PCT_MAX) ? PCT_MAX : prevent_percent;
    wire [7:0]         sl_c  = (slot_bytes > SLOT_MAX) ? SLOT_MAX : slot_bytes;
    wire [7:0]         sl_b  = (sl_c == SLOT_DEF) ? MIN_FRAME : sl_c;

    // byte counts to cycles; period multiplies every figure alike
    wire [TIME_W-1:0] fix_cyc = TIME_W'(fix_b) * TIME_W'(byte_period);
    wire [TIME_W-1:0] var_cyc = TIME_W'(var_b) * TIME_W'(byte_period);
    wire [TIME_W-1:0] txd_cyc = TIME_W'(txd_b) * TIME_W'(byte_period);
    wire [TIME_W-1:0] cpd_cyc = TIME_W'(cpd_b) * TIME_W'(byte_period);
    wire [TIME_W-1:0] sl_cyc  = TIME_W'(sl_b) * TIME_W'(byte_period);

    // retransmission timeout formula
    // the first send has sequence zero, so its progressive term stays zero
    wire              rto_en   = ack_enable && (retry_count != 4'h0);
    wire [4:0]        mult_r   = draw(rnd_mult, {1'b0, mult_m});
    wire [SEQ_W-1:0]  seq_m1   = (retry_sequence_number == '0) ? '0
                                 : retry_sequence_number - SEQ_W'(1);
    wire [TIME_W-1:0] prog_cyc = progressive_en ? fix_cyc * TIME_W'(seq_m1)
                                                : '0;
    wire [TIME_W-1:0] rto_calc = fix_cyc + var_cyc * TIME_W'(mult_r)
                                 + prog_cyc;
    wire              rto_take = timeout_req && rto_en;

    // slotted access: range chosen by the previous data event
    wire [4:0]        srange   = (last_ev_q == RMB_EV_TX) ? {1'b0, stx_m}
                                                          : {1'b0, srx_m};
    wire [4:0]        slot_r   = draw(rnd_slot, srange);
    wire [4:0]        slot_sum = slot_r + {1'b0, hc_m};
    wire [4:0]        slot_n   = (slot_sum > {1'b0, SLOT_CAP}) ? {1'b0, SLOT_CAP}
                                                               : slot_sum;
    wire [TIME_W-1:0] busy_cyc = sl_cyc * TIME_W'(slot_n)
                                 + txd_cyc;

    // free channel: delay only when the percentage draw hits
    wire [6:0]        pct_r    = draw7(rnd_pct);
    wire              cp_hit   = (pct_m != PCT_DEF) && (pct_r < pct_m);
    wire [TIME_W-1:0] free_cyc = cp_hit ? cpd_cyc : '0;
    wire [TIME_W-1:0] acc_calc = channel_busy ? busy_cyc : free_cyc;

    // remember the last data frame event; acks leave it unchanged
    // own transmission wins when both frames end in one cycle
    always_comb
    begin
        last_ev_d = last_ev_q;
        if (tx_frame_done && !frame_is_ack)
            last_ev_d = RMB_EV_TX;
        else if (rx_frame_done && !frame_is_ack)
            last_ev_d = RMB_EV_RX;
    end

    // timeout countdown; a new request restarts it, cancel stops it
    // a request beside a cancel wins, since a fresh frame needs its timer
    always_comb
    begin
        rto_d     = rto_q;
        rto_cnt_d = rto_cnt_q;
        rto_run_d = rto_run_q;
        rto_exp_d = 1'b0;
        if (rto_take)
        begin
            rto_d     = rto_calc;
            rto_cnt_d = rto_calc;
            rto_run_d = 1'b1;
        end
        else if (timeout_cancel)
        begin
            rto_run_d = 1'b0;
        end
        else if (rto_run_q)
        begin
            if (rto_cnt_q <= TIME_W'(1))
            begin
                rto_run_d = 1'b0;
                rto_exp_d = 1'b1;
                rto_cnt_d = '0;
            end
            else
            begin
                rto_cnt_d = rto_cnt_q - TIME_W'(1);
            end
        end
    end

    // access countdown; a zero delay grants on the next cycle at once
    // a new request restarts the wait, so a stale count never grants
    always_comb
    begin
        acc_d     = acc_q;
        acc_cnt_d = acc_cnt_q;
        acc_run_d = acc_run_q;
        acc_gnt_d = 1'b0;
        if (access_req)
        begin
            acc_d     = acc_calc;
            acc_cnt_d = acc_calc;
            acc_run_d = (acc_calc != '0);
            acc_gnt_d = (acc_calc == '0);
        end
        else if (acc_run_q)
        begin
            if (acc_cnt_q <= TIME_W'(1))
            begin
                acc_run_d = 1'b0;
                acc_gnt_d = 1'b1;
                acc_cnt_d = '0;
            end
            else
            begin
                acc_cnt_d = acc_cnt_q - TIME_W'(1);
            end
        end
    end

    // generator and event memory
    // the seed is nonzero so the shift register never locks at zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lfsr_q    <= LFSR_SEED;
            last_ev_q <= RMB_EV_RX;
        end
        else
        begin
            lfsr_q    <= lfsr_d;
            last_ev_q <= last_ev_d;
        end
    end

    // timeout registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rto_q     <= '0;
            rto_v_q   <= 1'b0;
            rto_cnt_q <= '0;
            rto_run_q <= 1'b0;
            rto_exp_q <= 1'b0;
        end
        else
        begin
            rto_q     <= rto_d;
            rto_v_q   <= rto_take;
            rto_cnt_q <= rto_cnt_d;
            rto_run_q <= rto_run_d;
            rto_exp_q <= rto_exp_d;
        end
    end

    // access registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            acc_q     <= '0;
            acc_v_q   <= 1'b0;
            acc_cnt_q <= '0;
            acc_run_q <= 1'b0;
            acc_gnt_q <= 1'b0;
        end
        else
        begin
            acc_q     <= acc_d;
            acc_v_q   <= access_req;
            acc_cnt_q <= acc_cnt_d;
            acc_run_q <= acc_run_d;
            acc_gnt_q <= acc_gnt_d;
        end
    end

    // outputs straight from flip-flops
    assign retry_timeout   = rto_q;
    assign timeout_valid   = rto_v_q;
    assign timeout_running = rto_run_q;
    assign timeout_expired = rto_exp_q;
    assign access_delay    = acc_q;
    assign access_valid    = acc_v_q;
    assign access_running  = acc_run_q;
    assign access_grant    = acc_gnt_q;
    assign last_event_tx   = (last_ev_q == RMB_EV_TX);

endmodule

// *** rtl/rmb_pkg.sv ***
// Purpose: shared constants for the radio mac backoff timing core
// Assumes: all byte counts are airtime in byte-transmission units
// Notes:   ranges are inclusive, values outside are clamped in the core
package rmb_pkg;

    // widths of the configuration fields
    localparam int BYTE_W      = 14;   // byte-count fields, up to 16000
    localparam int MULT_W      = 4;    // random multiplier maximum
    localparam int SLOTN_W     = 4;    // slot counts, handicap and slot cap
    localparam int PCT_W       = 7;    // probability in percent
    localparam int SEQ_W       = 4;    // retransmission sequence number
    localparam int PER_W       = 16;   // clock cycles per transmitted byte
    localparam int TIME_W      = 40;   // delays in clock cycles

    // retransmission timeout limits and defaults
    localparam logic [13:0] FIX_MIN     = 14'h000A;  // 10 bytes
    localparam logic [13:0] FIX_MAX     = 14'h2710;  // 10000 bytes
    localparam logic [13:0] FIX_DEF     = 14'h015E;  // 350 bytes
    localparam logic [13:0] VAR_MIN     = 14'h000A;  // 10 bytes
    localparam logic [13:0] VAR_MAX     = 14'h2710;  // 10000 bytes
    localparam logic [13:0] VAR_DEF     = 14'h015E;  // 350 bytes
    localparam logic [3:0]  MULT_MAX    = 4'hF;      // 15
    localparam logic [3:0]  MULT_DEF    = 4'h4;      // 4

    // busy channel access limits and defaults
    localparam logic [13:0] TXD_MAX     = 14'h3E80;  // 16000 bytes
    localparam logic [13:0] TXD_DEF     = 14'h0000;  // off
    localparam logic [7:0]  SLOT_MAX    = 8'hFA;     // 250 bytes
    localparam logic [7:0]  SLOT_DEF    = 8'h00;     // shortest frame
    localparam logic [3:0]  SLOTS_MAX   = 4'hC;      // 12 slots
    localparam logic [3:0]  SLOTS_RX_DEF = 4'h4;     // after reception
    localparam logic [3:0]  SLOTS_TX_DEF = 4'h6;     // after transmission
    localparam logic [3:0]  HCAP_MAX    = 4'h7;      // 7
    localparam logic [3:0]  HCAP_DEF    = 4'h0;      // 0
    localparam logic [3:0]  SLOT_CAP    = 4'hE;      // 14 slots at most

    // collision prevention limits and defaults
    localparam logic [6:0]  PCT_MAX     = 7'h64;     // 100 percent
    localparam logic [6:0]  PCT_DEF     = 7'h00;     // off
    localparam logic [13:0] CPD_MIN     = 14'h0001;  // 1 byte
    localparam logic [13:0] CPD_MAX     = 14'h3E80;  // 16000 bytes
    localparam logic [13:0] CPD_DEF     = 14'h000A;  // 10 bytes

    // reset value of the random generator, any nonzero value works
    localparam logic [31:0] LFSR_SEED   = 32'hACE1_2468;
    localparam logic [31:0] LFSR_TAPS   = 32'h8020_0003;

    // previous channel event that selects the slot-count range
    typedef enum logic [0:0] {
        RMB_EV_RX = 1'b0,
        RMB_EV_TX = 1'b1
    } rmb_event_t;

endpackage

// *** verif/rmb_backoff_sva.sv ***
// Purpose: port checks for the backoff timing core
// Assumes: one clock, reset high and asynchronous
// Notes:   counters measure each countdown against the value reported
`timescale 1ns/1ps
module rmb_backoff_sva
    import rmb_pkg::*;
(
    input wire logic                clk,                   // core clock
    input wire logic                rst,                   // async reset
    input wire logic [PER_W-1:0]    byte_period,           // cycles per byte
    input wire logic                ack_enable,            // ack on
    input wire logic [3:0]          retry_count,           // retries
    input wire logic                progressive_en,        // growth on
    input wire logic [BYTE_W-1:0]   fixed_wait_part,       // fixed bytes
    input wire logic [MULT_W-1:0]   max_random_multiplier, // multiplier max
    input wire logic [BYTE_W-1:0]   busy_extra_bytes,      // busy extra
    input wire logic [7:0]          slot_bytes,            // slot length
    input wire logic [PCT_W-1:0]    prevent_percent,       // probability
    input wire logic                rx_frame_done,         // frame heard
    input wire logic                tx_frame_done,         // frame sent
    input wire logic                frame_is_ack,          // was ack
    input wire logic                timeout_req,           // timeout start
    input wire logic                access_req,            // access start
    input wire logic                channel_busy,          // busy now
    input wire logic [TIME_W-1:0]   retry_timeout,         // timeout value
    input wire logic                timeout_valid,         // value pulse
    input wire logic                timeout_expired,       // expiry pulse
    input wire logic [TIME_W-1:0]   access_delay,          // access value
    input wire logic                access_valid,          // value pulse
    input wire logic                access_grant,          // grant pulse
    input wire logic                last_event_tx          // last was tx
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    logic [TIME_W-1:0] tcnt_q; // cycles since timeout value
    logic [TIME_W-1:0] acnt_q; // cycles since access value

    // restart on each value, so a retrigger never leaves a stale count
    always_ff @(posedge clk or posedge rst)
        if (rst) tcnt_q <= 40'h0;
        else if (timeout_valid) tcnt_q <= 40'h1;
        else tcnt_q <= tcnt_q + 40'h1;
    always_ff @(posedge clk or posedge rst)
        if (rst) acnt_q <= 40'h0;
        else if (access_valid) acnt_q <= 40'h1;
        else acnt_q <= acnt_q + 40'h1;

    chk_tmo_refused: assert property (timeout_req && !(ack_enable && retry_count != 4'h0)
        |=> !timeout_valid) else $error("timeout answered while disabled");
    chk_tmo_taken: assert property (timeout_req && ack_enable && retry_count != 4'h0
        |=> timeout_valid) else $error("timeout request not answered");
    chk_tmo_exact: assert property (timeout_valid && $past(max_random_multiplier) == 4'h0
        && !$past(progressive_en) && $past(fixed_wait_part) inside {[FIX_MIN:FIX_MAX]}
        |-> retry_timeout == TIME_W'($past(fixed_wait_part)) * TIME_W'($past(byte_period)))
        else $error("fixed timeout wrong");
    chk_tmo_expiry: assert property (timeout_expired |-> tcnt_q == retry_timeout)
        else $error("timeout expired at wrong cycle");
    chk_free_zero: assert property (access_req && !channel_busy && prevent_percent == 7'h00
        |=> access_valid && access_grant && access_delay == 40'h0)
        else $error("free channel delayed");
    chk_slot_cap: assert property (access_valid && $past(channel_busy)
        && $past(busy_extra_bytes) == 14'h0 && $past(slot_bytes) inside {[8'h01:SLOT_MAX]}
        |-> access_delay <= TIME_W'($past(slot_bytes)) * TIME_W'($past(byte_period)) * 40'hE)
        else $error("slot count above cap");
    chk_grant_time: assert property (access_grant && !access_valid |-> acnt_q == access_delay)
        else $error("grant at wrong cycle");
    chk_ack_kept: assert property ((rx_frame_done || tx_frame_done) && frame_is_ack
        |=> $stable(last_event_tx)) else $error("ack changed previous event");
    chk_tx_event: assert property (tx_frame_done && !frame_is_ack |=> last_event_tx)
        else $error("own data frame not remembered");
    chk_rx_event: assert property (rx_frame_done && !tx_frame_done && !frame_is_ack
        |=> !last_event_tx) else $error("reception not remembered");

    cover property (timeout_expired);
    cover property (access_grant && !access_valid);
    cover property (timeout_req && !ack_enable);
endmodule

bind rmb_backoff_core rmb_backoff_sva u_chk (.*);

// *** verif/rmb_air_model.sv ***
// Purpose: other stations sharing the channel, as seen by the core
// Assumes: busy state and frame ends arrive on the core clock
// Notes:   the ack qualifier shows its inverse when no frame ends
`timescale 1ns/1ps
module rmb_air_model
(
    input  wire logic clk,           // core clock
    output logic      channel_busy,  // carrier detected
    output logic      rx_frame_done, // frame heard
    output logic      tx_frame_done, // own frame finished
    output logic      frame_is_ack   // finished frame is ack
);
    // quiet channel at start
    initial
    begin
        channel_busy  = 1'b0;
        rx_frame_done = 1'b0;
        tx_frame_done = 1'b0;
        frame_is_ack  = 1'b0;
    end
    // busy level stays until changed
    task automatic occupy(input logic busy);
        @(posedge clk);
        channel_busy <= busy;
    endtask
    // one-cycle frame end; qualifier flips after so stale values are not trusted
    task automatic frame_end(input logic own, input logic ack);
        @(posedge clk);
        tx_frame_done <= own;
        rx_frame_done <= !own;
        frame_is_ack  <= ack;
        @(posedge clk);
        tx_frame_done <= 1'b0;
        rx_frame_done <= 1'b0;
        frame_is_ack  <= !ack;
    endtask
endmodule

// *** verif/tb_rmb_backoff_core.sv ***
// Purpose: directed bench for the backoff timing core
// Assumes: 25 MHz clock, two cycles per byte
// Notes:   random draws are judged by range, fixed cases exactly
`timescale 1ns/1ps
module tb_rmb_backoff_core
    import rmb_pkg::*;
;
    logic clk, rst = 1'b1, ack_enable = 1'b1, progressive_en = 1'b0;
    logic timeout_req = 1'b0, timeout_cancel = 1'b0, access_req = 1'b0;
    logic [PER_W-1:0]  byte_period = 16'h2;
    logic [3:0]        retry_count = 4'h3, max_random_multiplier = 4'h0;
    logic [3:0]        retry_sequence_number = 4'h0;
    logic [3:0]        slots_after_rx = 4'h0, slots_after_tx = 4'h0, slot_handicap = 4'h7;
    logic [BYTE_W-1:0] fixed_wait_part = 14'hA, random_wait_unit = 14'hA;
    logic [BYTE_W-1:0] busy_extra_bytes = 14'h0, prevent_bytes = 14'hA;
    logic [7:0]        slot_bytes = 8'h0;
    logic [PCT_W-1:0]  prevent_percent = 7'h0;
    logic channel_busy, rx_frame_done, tx_frame_done, frame_is_ack, timeout_valid;
    logic timeout_running, timeout_expired, access_valid, access_running, access_grant;
    logic last_event_tx;
    logic [TIME_W-1:0] retry_timeout, access_delay;
    int   bad_count = 0, compares = 0, n;
    // expected values worked out at two cycles per byte, 16-byte shortest frame
    logic [13:0] fx [4] = '{14'hA, 14'hA, 14'h5, 14'h3FFF};
    logic        pg [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [3:0]  nr [4] = '{4'h0, 4'h3, 4'h0, 4'h0};
    logic [39:0] te [4] = '{40'h14, 40'h3C, 40'h14, 40'h4E20};
    logic        ab [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [13:0] ax [6] = '{14'h0, 14'h3, 14'h3, 14'h3, 14'h3, 14'h3};
    logic [6:0]  ap [6] = '{7'h0, 7'h0, 7'h0, 7'h64, 7'h64, 7'h64};
    logic [13:0] ac [6] = '{14'hA, 14'hA, 14'hA, 14'hA, 14'h0, 14'hA};
    logic [39:0] ae [6] = '{40'hE0, 40'hE6, 40'h0, 40'h14, 40'h2, 40'hE6};

    rmb_backoff_core u_dut (.*);
    rmb_air_model u_air (.*);

    // free-running 40 ns clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // request held one edge, answer looked at just after the next edge
    task automatic tmo(input logic [3:0] seq);
        @(posedge clk);
        timeout_req <= 1'b1;
        retry_sequence_number <= seq;
        @(posedge clk);
        timeout_req <= 1'b0;
        #1;
    endtask
    task automatic acc(input logic busy);
        u_air.occupy(busy);
        @(posedge clk);
        access_req <= 1'b1;
        @(posedge clk);
        access_req <= 1'b0;
        #1;
        check("access valid", 40'h1, {39'h0, access_valid});
    endtask
    // bounded wait counting cycles until grant or expiry
    task automatic wait_for(input logic grant);
        n = 0;
        while ((grant ? access_grant : timeout_expired) !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic ev(input logic own, input logic ack, input logic exp);
        u_air.frame_end(own, ack);
        #1;
        check("last event", {39'h0, exp}, {39'h0, last_event_tx});
    endtask
    task automatic give_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            fixed_wait_part <= fx[i];
            progressive_en  <= pg[i];
            tmo(nr[i]);
            check("timeout", te[i], retry_timeout);
        end
        @(posedge clk);
        fixed_wait_part <= 14'hA;
        tmo(4'h0);
        wait_for(1'b0);
        check("expiry", 40'h14, TIME_W'(n));
        tmo(4'h0);
        check("running", 40'h1, {39'h0, timeout_running});
        @(posedge clk);
        timeout_cancel <= 1'b1;
        @(posedge clk);
        timeout_cancel <= 1'b0;
        #1;
        check("cancel", 40'h0, {39'h0, timeout_running});
        @(posedge clk);
        max_random_multiplier <= 4'hF;
        repeat (6)
        begin
            tmo(4'h0);
            check("random step", 40'h0, retry_timeout % 40'h14);
            check("random max", 40'h1, {39'h0, retry_timeout <= 40'h140});
        end
        @(posedge clk);
        ack_enable <= 1'b0;
        tmo(4'h0);
        check("ack off", 40'h0, {39'h0, timeout_valid});
        @(posedge clk);
        ack_enable  <= 1'b1;
        retry_count <= 4'h0;
        tmo(4'h0);
        check("no retries", 40'h0, {39'h0, timeout_valid});
        $display("test timeout done");
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            busy_extra_bytes <= ax[i];
            prevent_percent  <= ap[i];
            prevent_bytes    <= ac[i];
            acc(ab[i]);
            check("access", ae[i], access_delay);
            check("busy wait", {39'h0, ae[i] != 40'h0}, {39'h0, access_running});
            wait_for(1'b1);
            check("grant", ae[i], TIME_W'(n));
        end
        @(posedge clk);
        slot_bytes       <= 8'h10;
        slots_after_rx   <= 4'hC;
        busy_extra_bytes <= 14'h0;
        repeat (8)
        begin
            acc(1'b1);
            check("slot step", 40'h0, access_delay % 40'h20);
            check("slot cap", 40'h1, {39'h0, access_delay inside {[40'hE0:40'h1C0]}});
        end
        @(posedge clk);
        slot_handicap <= 4'h1;
        ev(1'b1, 1'b1, 1'b0);
        ev(1'b1, 1'b0, 1'b1);
        acc(1'b1);
        check("after tx", 40'h20, access_delay);
        ev(1'b0, 1'b1, 1'b1);
        ev(1'b0, 1'b0, 1'b0);
        $display("test access done");
        give_verdict();
    end

    // hang guard, far beyond the several hundred cycles the tests need
    initial
    begin
        repeat (30000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
endmodule
